// *** design/fine_dac_override_bank.v ***
// Fine DAC override register bank for both optical channels, top level
// Function
// [RQ1] Channel one flag clear: chip picks the fine DAC code automatically.
// [RQ2] Offset 0x30 holds channel one exposure five flag and code.
// [RQ3] Offset 0x31 holds channel one exposure six flag and code.
// [RQ4] Channel one flag set: bits five to zero become the DAC code.
// [RQ5] Channel one flag clear: stored code has no effect on conversion.
// [RQ6] Offsets 0x32 to 0x36 hold channel two exposures one to five.
// [RQ7] Channel two flag clear: chip picks the fine DAC code automatically.
// [RQ8] Channel two flag set: bits five to zero become the DAC code.
// [RQ9] Channel two flag clear: stored code is ignored.
// [RQ10] Software may steer subranging per exposure through flags and codes.
// [RQ11] Channel one exposures one to four sit at 0x2C to 0x2F.
// [RQ12] Channel two exposure six sits at 0x37, same behaviour.
// [RQ13] Flag in bit seven, bit six reads zero, all fields reset zero.
`timescale 1ns/1ps
`include "fine_dac_defs.vh"

module fine_dac_override_bank #(
  parameter SLOTS = `SLOTS_PER_CHANNEL,
  parameter CODE_W = `CODE_WIDTH
) (
  // Clock, reset and enable
  input wire core_clk,
  input wire reset,
  input wire ce,
  // Register port from the serial interface
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  output reg reg_hit,
  // Channel one conversion request
  input wire ch1_conv_req,
  input wire [2:0] ch1_exposure,
  input wire [CODE_W-1:0] ch1_auto_code,
  // Channel one conversion answer
  output reg ch1_code_valid,
  output reg [CODE_W-1:0] ch1_dac_code,
  output reg ch1_code_from_sw,
  // Channel two conversion request
  input wire ch2_conv_req,
  input wire [2:0] ch2_exposure,
  input wire [CODE_W-1:0] ch2_auto_code,
  // Channel two conversion answer
  output reg ch2_code_valid,
  output reg [CODE_W-1:0] ch2_dac_code,
  output reg ch2_code_from_sw,
  // Flag summaries, slot one in bit zero
  output reg [SLOTS-1:0] ch1_override_flags,
  output reg [SLOTS-1:0] ch2_override_flags
);

  localparam TOTAL = 2 * SLOTS;

  // ========================================================================
  // Address decode
  wire in_bank;
  wire [7:0] slot_offset;
  wire [3:0] slot_index;

  assign in_bank = (reg_addr >= `BANK_FIRST_OFS) && (reg_addr <= `BANK_LAST_OFS);
  assign slot_offset = reg_addr - `BANK_FIRST_OFS;
  // Slots 0..5 are channel one, 6..11 channel two, in ascending offset
  assign slot_index = slot_offset[3:0]; // see [RQ2] see [RQ3] see [RQ6] see [RQ11] see [RQ12]

  // ========================================================================
  // Slot registers
  wire [TOTAL-1:0] slot_override;
  wire [TOTAL*CODE_W-1:0] slot_code;

  genvar g;
  generate
    for (g = 0; g < TOTAL; g = g + 1) begin : slot
      wire slot_we;
      assign slot_we = reg_wr && in_bank && (slot_index == g); // see [RQ10]
      override_slot #(
        .CODE_W(CODE_W)
      ) u_slot (
        .core_clk(core_clk),
        .reset(reset),
        .ce(ce),
        .write_en(slot_we),
        .write_data(reg_wdata),
        .override_reg(slot_override[g]),
        .code_reg(slot_code[g*CODE_W +: CODE_W])
      );
    end
  endgenerate

  // ========================================================================
  // Read path
  reg [7:0] read_next;
  reg [CODE_W-1:0] read_code;
  reg read_flag;

  always @* begin
    read_code = slot_code[slot_index*CODE_W +: CODE_W];
    read_flag = slot_override[slot_index];
    read_next = `UNMAPPED_READ;
    if (in_bank) begin
      read_next[`OVERRIDE_BIT] = read_flag;
      read_next[`RESERVED_BIT] = 1'b0; // see [RQ13]
      read_next[`CODE_MSB:`CODE_LSB] = read_code;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= `UNMAPPED_READ;
      reg_rvalid <= 1'b0;
      reg_hit <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= read_next;
        reg_hit <= in_bank;
      end
    end
  end

  // ========================================================================
  // Code selection per channel
  wire [CODE_W-1:0] ch1_sel_code;
  wire ch1_sel_sw;
  wire [CODE_W-1:0] ch2_sel_code;
  wire ch2_sel_sw;

  // Channel one uses the lower half of the bank
  dac_code_select #(
    .SLOTS(SLOTS),
    .CODE_W(CODE_W)
  ) u_ch1_select (
    .exposure(ch1_exposure),
    .auto_code(ch1_auto_code),
    .override_flags(slot_override[SLOTS-1:0]),
    .sw_codes(slot_code[SLOTS*CODE_W-1:0]),
    .applied_code(ch1_sel_code), // see [RQ1] see [RQ4] see [RQ5]
    .from_software(ch1_sel_sw)
  );

  dac_code_select #(
    .SLOTS(SLOTS),
    .CODE_W(CODE_W)
  ) u_ch2_select (
    .exposure(ch2_exposure),
    .auto_code(ch2_auto_code),
    .override_flags(slot_override[TOTAL-1:SLOTS]),
    .sw_codes(slot_code[TOTAL*CODE_W-1:SLOTS*CODE_W]),
    .applied_code(ch2_sel_code), // see [RQ7] see [RQ8] see [RQ9]
    .from_software(ch2_sel_sw)
  );

  // ========================================================================
  // Registered answers to the converters
  always @(posedge core_clk) begin
    if (reset) begin
      ch1_code_valid <= 1'b0;
      ch1_dac_code <= `CODE_RESET;
      ch1_code_from_sw <= 1'b0;
      ch2_code_valid <= 1'b0;
      ch2_dac_code <= `CODE_RESET;
      ch2_code_from_sw <= 1'b0;
    end else if (ce) begin
      ch1_code_valid <= ch1_conv_req;
      ch2_code_valid <= ch2_conv_req;
      // Code holds between requests so the DAC never sees a glitch
      if (ch1_conv_req) begin
        ch1_dac_code <= ch1_sel_code; // see [RQ4] see [RQ5]
        ch1_code_from_sw <= ch1_sel_sw;
      end
      if (ch2_conv_req) begin
        ch2_dac_code <= ch2_sel_code; // see [RQ8] see [RQ9]
        ch2_code_from_sw <= ch2_sel_sw;
      end
    end
  end

  // ========================================================================
  // Flag summaries, one cycle behind the slot registers
  always @(posedge core_clk) begin
    if (reset) begin
      ch1_override_flags <= {SLOTS{1'b0}};
      ch2_override_flags <= {SLOTS{1'b0}};
    end else if (ce) begin
      ch1_override_flags <= slot_override[SLOTS-1:0];
      ch2_override_flags <= slot_override[TOTAL-1:SLOTS];
    end
  end

endmodule // fine_dac_override_bank

// *** design/fine_dac_defs.vh ***
// Register map, field layout and reset values of the fine DAC override bank
`ifndef FINE_DAC_DEFS_VH
`define FINE_DAC_DEFS_VH

// ==========================================================================
// Register offsets (byte addresses on the register port)
`define OFS_OPTICAL_CHANNEL_ONE_EXP1_FINE_DAC 8'h2C
`define OFS_OPTICAL_CHANNEL_ONE_EXP2_FINE_DAC 8'h2D
`define OFS_OPTICAL_CHANNEL_ONE_EXP3_FINE_DAC 8'h2E
`define OFS_OPTICAL_CHANNEL_ONE_EXP4_FINE_DAC 8'h2F
`define OFS_OPTICAL_CHANNEL_ONE_EXP5_FINE_DAC 8'h30
`define OFS_OPTICAL_CHANNEL_ONE_EXP6_FINE_DAC 8'h31
`define OFS_OPTICAL_CHANNEL_TWO_EXP1_FINE_DAC 8'h32
`define OFS_OPTICAL_CHANNEL_TWO_EXP2_FINE_DAC 8'h33
`define OFS_OPTICAL_CHANNEL_TWO_EXP3_FINE_DAC 8'h34
`define OFS_OPTICAL_CHANNEL_TWO_EXP4_FINE_DAC 8'h35
`define OFS_OPTICAL_CHANNEL_TWO_EXP5_FINE_DAC 8'h36
`define OFS_OPTICAL_CHANNEL_TWO_EXP6_FINE_DAC 8'h37

// ==========================================================================
// Bank geometry
`define BANK_FIRST_OFS 8'h2C
`define BANK_LAST_OFS 8'h37
`define SLOTS_PER_CHANNEL 6
`define BANK_SLOTS 12

// ==========================================================================
// Field layout
`define OVERRIDE_BIT 7
`define RESERVED_BIT 6
`define CODE_MSB 5
`define CODE_LSB 0
`define CODE_WIDTH 6

// ==========================================================================
// Reset values
`define OVERRIDE_RESET 1'h0
`define CODE_RESET 6'h00
`define UNMAPPED_READ 8'h00

// ==========================================================================
// Exposure numbering on the chip side
`define EXPOSURE_FIRST 3'h1
`define EXPOSURE_LAST 3'h6

`endif

// *** design/override_slot.v ***
// One override register: flag and six-bit code, reserved bit not stored
`timescale 1ns/1ps
`include "fine_dac_defs.vh"

module override_slot #(
  parameter CODE_W = `CODE_WIDTH
) (
  // Clock, reset and enable
  input wire core_clk,
  input wire reset,
  input wire ce,
  // Write side
  input wire write_en,
  input wire [7:0] write_data,
  // Stored fields
  output reg override_reg,
  output reg [CODE_W-1:0] code_reg
);

  // ========================================================================
  // Storage
  always @(posedge core_clk) begin
    if (reset) begin
      override_reg <= `OVERRIDE_RESET; // see [RQ13]
      code_reg <= `CODE_RESET; // see [RQ13]
    end else if (ce && write_en) begin
      // Reserved bit is dropped here so it can never read back as one
      override_reg <= write_data[`OVERRIDE_BIT]; // see [RQ13]
      code_reg <= write_data[`CODE_MSB:`CODE_LSB];
    end
  end

endmodule // override_slot

// *** design/dac_code_select.v ***
// Chooses between the chip's automatic code and the software code of one channel
`timescale 1ns/1ps
`include "fine_dac_defs.vh"

module dac_code_select #(
  parameter SLOTS = `SLOTS_PER_CHANNEL,
  parameter CODE_W = `CODE_WIDTH
) (
  // Exposure being converted and the chip's own choice
  input wire [2:0] exposure,
  input wire [CODE_W-1:0] auto_code,
  // Software fields of this channel, slot 1 in the lowest lane
  input wire [SLOTS-1:0] override_flags,
  input wire [SLOTS*CODE_W-1:0] sw_codes,
  // Result
  output reg [CODE_W-1:0] applied_code,
  output reg from_software
);

  integer i;

  // ========================================================================
  // Selection
  always @* begin
    applied_code = auto_code;
    from_software = 1'b0;
    for (i = 0; i < SLOTS; i = i + 1) begin
      // Stored code reaches the DAC only through the flag gate
      if ((exposure == i + 1) && override_flags[i]) begin
        applied_code = sw_codes[i*CODE_W +: CODE_W];
        from_software = 1'b1;
      end
    end
  end

endmodule // dac_code_select

// *** test/fine_dac_bank_checker.sv ***
// Port-level assertions for the fine DAC override bank
`timescale 1ns/1ps
module fine_dac_bank_checker #(
  parameter SLOTS = 6,
  parameter CODE_W = 6
) (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  input wire ce,
  // Register port
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire reg_rvalid,
  input wire reg_hit,
  // Channel one
  input wire ch1_conv_req,
  input wire [2:0] ch1_exposure,
  input wire [CODE_W-1:0] ch1_auto_code,
  input wire ch1_code_valid,
  input wire [CODE_W-1:0] ch1_dac_code,
  input wire ch1_code_from_sw,
  input wire [SLOTS-1:0] ch1_override_flags,
  // Channel two
  input wire ch2_conv_req,
  input wire [2:0] ch2_exposure,
  input wire [CODE_W-1:0] ch2_auto_code,
  input wire ch2_code_valid,
  input wire [CODE_W-1:0] ch2_dac_code,
  input wire ch2_code_from_sw,
  input wire [SLOTS-1:0] ch2_override_flags
);
  // ==========================================================================
  // Checks
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  AST_RD_ANSWER: assert property (ce && reg_rd |=> reg_rvalid && !reg_rdata[6])
    else $error("read answer missing or bit 6 set");
  AST_UNMAPPED: assert property (ce && reg_rd && (reg_addr < 8'h2C || reg_addr > 8'h37)
    |=> !reg_hit && reg_rdata == 8'h00) else $error("unmapped read not refused");
  AST_MAPPED: assert property (ce && reg_rd && reg_addr >= 8'h30 && reg_addr <= 8'h36
    |=> reg_hit) else $error("mapped read missed");
  AST_C1_VALID: assert property (ce && ch1_conv_req |=> ch1_code_valid)
    else $error("channel one answer missing");
  AST_C2_VALID: assert property (ce && ch2_conv_req |=> ch2_code_valid)
    else $error("channel two answer missing");
  AST_C1_AUTO: assert property (ce && ch1_conv_req && ch1_exposure inside {3'h5, 3'h6}
    && !ch1_override_flags[ch1_exposure - 3'h1]
    |=> ch1_dac_code == $past(ch1_auto_code) && !ch1_code_from_sw)
    else $error("channel one auto code not used");
  AST_C1_SW: assert property (ce && ch1_conv_req && ch1_exposure inside {3'h5, 3'h6}
    && ch1_override_flags[ch1_exposure - 3'h1] |=> ch1_code_from_sw)
    else $error("channel one software code not used");
  AST_C2_AUTO: assert property (ce && ch2_conv_req && ch2_exposure inside {[3'h1:3'h5]}
    && !ch2_override_flags[ch2_exposure - 3'h1]
    |=> ch2_dac_code == $past(ch2_auto_code) && !ch2_code_from_sw)
    else $error("channel two auto code not used");
  AST_C2_SW: assert property (ce && ch2_conv_req && ch2_exposure inside {[3'h1:3'h5]}
    && ch2_override_flags[ch2_exposure - 3'h1] |=> ch2_code_from_sw)
    else $error("channel two software code not used");
endmodule // fine_dac_bank_checker

bind fine_dac_override_bank fine_dac_bank_checker #(.SLOTS(SLOTS), .CODE_W(CODE_W)) i_chk (
  .core_clk(core_clk), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
  .ch1_conv_req(ch1_conv_req), .ch1_exposure(ch1_exposure), .ch1_auto_code(ch1_auto_code),
  .ch1_code_valid(ch1_code_valid), .ch1_dac_code(ch1_dac_code),
  .ch1_code_from_sw(ch1_code_from_sw), .ch1_override_flags(ch1_override_flags),
  .ch2_conv_req(ch2_conv_req), .ch2_exposure(ch2_exposure), .ch2_auto_code(ch2_auto_code),
  .ch2_code_valid(ch2_code_valid),
  .ch2_dac_code(ch2_dac_code), .ch2_code_from_sw(ch2_code_from_sw),
  .ch2_override_flags(ch2_override_flags));

// *** test/tb.sv ***
// Self-checking bench for the fine DAC override bank
`timescale 1ns/1ps
module tb;
  reg core_clk = 1'b0;
  reg reset = 1'b1;
  reg ce = 1'b1;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg [1:0] conv_req = 2'h0;
  reg [2:0] exp1 = 3'h0, exp2 = 3'h0;
  reg [5:0] auto1 = 6'h00, auto2 = 6'h00;
  reg [7:0] mdl [0:11];
  wire [7:0] reg_rdata;
  wire reg_rvalid, reg_hit;
  wire [1:0] cvalid, csw;
  wire [5:0] code1, code2, flags1, flags2;
  integer err_total = 0, n_checks = 0, cycles = 0, i;
  fine_dac_override_bank i_dut (.core_clk(core_clk), .reset(reset), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
    .ch1_conv_req(conv_req[0]), .ch1_exposure(exp1), .ch1_auto_code(auto1),
    .ch1_code_valid(cvalid[0]), .ch1_dac_code(code1), .ch1_code_from_sw(csw[0]),
    .ch2_conv_req(conv_req[1]), .ch2_exposure(exp2), .ch2_auto_code(auto2),
    .ch2_code_valid(cvalid[1]), .ch2_dac_code(code2), .ch2_code_from_sw(csw[1]),
    .ch1_override_flags(flags1), .ch2_override_flags(flags2));
  always #12.5 core_clk = ~core_clk;
  // ==========================================================================
  // Access tasks
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("unexpected %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task step;
    begin
      @(posedge core_clk);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      // Bank model keeps bit 6 clear, so readback checks the reserved bit
      if (a >= 8'h2C && a <= 8'h37) mdl[a - 8'h2C] = d & 8'hBF;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      step;
      reg_wr = 1'b0;
      step;
    end
  endtask
  task rd(input [7:0] a);
    reg m;
    reg [7:0] ev;
    begin
      m = a >= 8'h2C && a <= 8'h37;
      ev = m ? mdl[a - 8'h2C] : 8'h00;
      reg_addr = a;
      reg_rd = 1'b1;
      step;
      chk("rvalid", 8'h01, {7'h00, reg_rvalid});
      chk("rdata", ev, reg_rdata);
      chk("hit", {7'h00, m}, {7'h00, reg_hit});
      reg_rd = 1'b0;
      step;
      chk("rvalid_end", 8'h00, {7'h00, reg_rvalid});
      chk("rdata_hold", ev, reg_rdata);
    end
  endtask
  task conv(input [2:0] x, input [5:0] au);
    reg [7:0] s1, s2;
    reg [5:0] e1, e2;
    begin
      s1 = (x >= 3'h1 && x <= 3'h6) ? mdl[x - 3'h1] : 8'h00;
      s2 = (x >= 3'h1 && x <= 3'h6) ? mdl[x + 5] : 8'h00;
      e1 = s1[7] ? s1[5:0] : au;
      e2 = s2[7] ? s2[5:0] : ~au;
      exp1 = x;
      exp2 = x;
      auto1 = au;
      auto2 = ~au;
      conv_req = 2'h3;
      step;
      chk("valid", 8'h03, {6'h00, cvalid});
      chk("code1", {2'h0, e1}, {2'h0, code1});
      chk("code2", {2'h0, e2}, {2'h0, code2});
      chk("fromsw", {6'h00, s2[7], s1[7]}, {6'h00, csw});
      chk("flags1", {2'h0, mdl[5][7], mdl[4][7], mdl[3][7], mdl[2][7], mdl[1][7], mdl[0][7]},
        {2'h0, flags1});
      chk("flags2", {2'h0, mdl[11][7], mdl[10][7], mdl[9][7], mdl[8][7], mdl[7][7], mdl[6][7]},
        {2'h0, flags2});
      conv_req = 2'h0;
      // Inputs move while idle: the answer must hold regardless
      auto1 = ~au;
      auto2 = au;
      step;
      chk("valid_end", 8'h00, {6'h00, cvalid});
      chk("code1_hold", {2'h0, e1}, {2'h0, code1});
      chk("code2_hold", {2'h0, e2}, {2'h0, code2});
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  // Hang guard, far above the roughly 150 cycles the sequence needs
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      err_total = err_total + 1;
      complete_run;
    end
  end
  initial begin
    for (i = 0; i < 12; i = i + 1) mdl[i] = 8'h00;
    repeat (4) @(posedge core_clk);
    #1;
    reset = 1'b0;
    for (i = 8'h2B; i <= 8'h38; i = i + 1) rd(i[7:0]);
    for (i = 8'h30; i <= 8'h36; i = i + 1) wr(i[7:0], 8'hC0 | (i[7:0] ^ 8'h2A));
    wr(8'h2C, 8'h3F);
    wr(8'h37, 8'h80);
    wr(8'h40, 8'hFF);
    for (i = 8'h2B; i <= 8'h40; i = i + 1) rd(i[7:0]);
    for (i = 0; i < 8; i = i + 1) conv(i[2:0], 6'h15);
    // Flags off at 0x30 to 0x36 with codes rewritten to 3F: those codes must not leak through
    for (i = 8'h30; i <= 8'h36; i = i + 1) wr(i[7:0], 8'h3F);
    for (i = 0; i < 8; i = i + 1) conv(i[2:0], 6'h2A);
    // Frozen enable: write and read in that cycle are both ignored
    ce = 1'b0;
    reg_addr = 8'h31;
    reg_wdata = 8'h85;
    reg_wr = 1'b1;
    reg_rd = 1'b1;
    step;
    chk("frozen_rvalid", 8'h00, {7'h00, reg_rvalid});
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ce = 1'b1;
    step;
    rd(8'h31);
    // Mid-run reset returns every slot to automatic control
    wr(8'h33, 8'hA5);
    reset = 1'b1;
    step;
    step;
    reset = 1'b0;
    for (i = 0; i < 12; i = i + 1) mdl[i] = 8'h00;
    chk("rst_flags1", 8'h00, {2'h0, flags1});
    chk("rst_flags2", 8'h00, {2'h0, flags2});
    chk("rst_rdata", 8'h00, reg_rdata);
    rd(8'h33);
    conv(3'h3, 6'h0C);
    complete_run;
  end
endmodule // tb
